// ===== cjar_readout.v
// Cold-junction temperature and raw ADC sample result registers.
`timescale 1ns/1ps
`include "cjar_consts.vh"

module cjar_readout #(
    parameter CJ_FINE_CYCLES   = (`CJAR_CLK_HZ / 1000) * `CJAR_CJ_FINE_MS,
    parameter CJ_COARSE_CYCLES = (`CJAR_CLK_HZ / 1000) * `CJAR_CJ_COARSE_MS,
    parameter ADC_18_CYCLES    = (`CJAR_CLK_HZ / 1000) * `CJAR_ADC_18_MS,
    parameter ADC_16_CYCLES    = (`CJAR_CLK_HZ / 1000) * `CJAR_ADC_16_MS,
    parameter ADC_14_CYCLES    = (`CJAR_CLK_HZ / 1000) * `CJAR_ADC_14_MS,
    parameter ADC_12_CYCLES    = (`CJAR_CLK_HZ / 1000) * `CJAR_ADC_12_MS
) (
    // Clock and reset
    input  wire        clk_in,
    input  wire        rstn_in,
    // Resolution selects
    input  wire        cj_coarse_in,
    input  wire [1:0]  adc_res_in,
    // Front-end samples
    input  wire [11:0] cj_sample_in,
    input  wire [17:0] adc_sample_in,
    // Result registers
    output reg  [15:0] cold_junction_temperature_out,
    output reg  [23:0] raw_adc_sample_out,
    // Conversion-done strobes
    output reg         cj_update_out,
    output reg         adc_update_out
);

    // Field sizes of the two result words.
    localparam CJ_DATA_W  = `CJAR_CJ_SIGN_LSB;
    localparam CJ_FILL_W  = `CJAR_CJ_WIDTH - `CJAR_CJ_SIGN_LSB;
    localparam ADC_DATA_W = `CJAR_ADC_BITS;
    localparam ADC_FILL_W = `CJAR_ADC_WIDTH - `CJAR_ADC_BITS;

    // Conversion timers.
    reg  [31:0] cj_count;
    reg  [31:0] adc_count;
    reg  [31:0] next_cj_count;
    reg  [31:0] next_adc_count;
    reg  [31:0] cj_period;
    reg  [31:0] adc_period;
    wire        cj_expire;
    wire        adc_expire;

    // Resolution masks and next register contents.
    reg  [11:0] cj_mask;
    reg  [17:0] adc_mask;
    reg  [15:0] next_cold_junction_temperature;
    reg  [23:0] next_raw_adc_sample;

    // Timer expiry. The period is read every cycle, so a resolution change
    // takes effect at once and may cut short the conversion in flight.
    function timer_done;
        input [31:0] count;
        input [31:0] period;
        begin
            timer_done = (count >= period - 32'h0000_0001);
        end
    endfunction

    // Cold-junction update interval for the selected resolution.
    function [31:0] cj_period_of;
        input coarse;
        begin
            if (coarse) begin
                cj_period_of = CJ_COARSE_CYCLES;
            end else begin
                cj_period_of = CJ_FINE_CYCLES;
            end
        end
    endfunction

    // Cold-junction data mask: the coarse setting drops the two lowest bits.
    function [11:0] cj_mask_of;
        input coarse;
        begin
            if (coarse) begin
                cj_mask_of = `CJAR_CJ_COARSE_MASK;
            end else begin
                cj_mask_of = `CJAR_CJ_FINE_MASK;
            end
        end
    endfunction

    // Raw ADC conversion time for the selected resolution.
    function [31:0] adc_period_of;
        input [1:0] res;
        begin
            case (res)
                `CJAR_RES_18: begin
                    adc_period_of = ADC_18_CYCLES;
                end
                `CJAR_RES_16: begin
                    adc_period_of = ADC_16_CYCLES;
                end
                `CJAR_RES_14: begin
                    adc_period_of = ADC_14_CYCLES;
                end
                default: begin
                    adc_period_of = ADC_12_CYCLES;
                end
            endcase
        end
    endfunction

    // Raw ADC data mask: each step down in resolution clears two more low bits.
    function [17:0] adc_mask_of;
        input [1:0] res;
        begin
            case (res)
                `CJAR_RES_18: begin
                    adc_mask_of = `CJAR_ADC_18_MASK;
                end
                `CJAR_RES_16: begin
                    adc_mask_of = `CJAR_ADC_16_MASK;
                end
                `CJAR_RES_14: begin
                    adc_mask_of = `CJAR_ADC_14_MASK;
                end
                default: begin
                    adc_mask_of = `CJAR_ADC_12_MASK;
                end
            endcase
        end
    endfunction

    // Sign-extended cold-junction word built from a masked sample.
    function [15:0] cj_word;
        input [11:0] sample;
        input [11:0] mask;
        begin
            cj_word = {{CJ_FILL_W{sample[CJ_DATA_W-1]}}, sample & mask};
        end
    endfunction

    // Sign-extended raw ADC word built from a masked sample.
    function [23:0] adc_word;
        input [17:0] sample;
        input [17:0] mask;
        begin
            adc_word = {{ADC_FILL_W{sample[ADC_DATA_W-1]}}, sample & mask};
        end
    endfunction

    // Resolution decode; the selects are levels and are taken as they stand.
    always @* begin
        cj_period  = cj_period_of(cj_coarse_in);
        cj_mask    = cj_mask_of(cj_coarse_in);
        adc_period = adc_period_of(adc_res_in);
        adc_mask   = adc_mask_of(adc_res_in);
    end

    assign cj_expire  = timer_done(cj_count, cj_period);
    assign adc_expire = timer_done(adc_count, adc_period);

    // Timers restart from zero on expiry, so the two streams run independently.
    always @* begin
        if (cj_expire) begin
            next_cj_count = 32'h0000_0000;
        end else begin
            next_cj_count = cj_count + 32'h0000_0001;
        end
        if (adc_expire) begin
            next_adc_count = 32'h0000_0000;
        end else begin
            next_adc_count = adc_count + 32'h0000_0001;
        end
    end

    // The readable copy is replaced as a whole word at expiry and held otherwise,
    // so a host never sees a mix of two conversions.
    always @* begin
        if (cj_expire) begin
            next_cold_junction_temperature =
                cj_word(cj_sample_in, cj_mask);
        end else begin
            next_cold_junction_temperature = cold_junction_temperature_out;
        end
        if (adc_expire) begin
            next_raw_adc_sample = adc_word(adc_sample_in, adc_mask);
        end else begin
            next_raw_adc_sample = raw_adc_sample_out;
        end
    end

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cj_count  <= 32'h0000_0000;
            adc_count <= 32'h0000_0000;
        end else begin
            cj_count  <= next_cj_count;
            adc_count <= next_adc_count;
        end
    end

    // Both result words read zero from reset until their first transfer.
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cold_junction_temperature_out <= `CJAR_CJ_RESET;
            raw_adc_sample_out            <= `CJAR_ADC_RESET;
        end else begin
            cold_junction_temperature_out <= next_cold_junction_temperature;
            raw_adc_sample_out            <= next_raw_adc_sample;
        end
    end

    // One-cycle strobes that rise with the register load they announce.
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cj_update_out  <= 1'b0;
            adc_update_out <= 1'b0;
        end else begin
            cj_update_out  <= cj_expire;
            adc_update_out <= adc_expire;
        end
    end

endmodule

// ===== cjar_consts.vh
// Constants for the cold-junction and raw ADC result registers.
`ifndef CJAR_CONSTS_VH
`define CJAR_CONSTS_VH
`define CJAR_CJ_WIDTH       16
`define CJAR_ADC_WIDTH      24
`define CJAR_ADC_BITS       18
`define CJAR_CJ_RESET       16'h0000
`define CJAR_ADC_RESET      24'h00_0000
`define CJAR_CJ_SIGN_LSB    12
`define CJAR_CJ_FINE_MS     250
`define CJAR_CJ_COARSE_MS   63
`define CJAR_ADC_18_MS      320
`define CJAR_ADC_16_MS      80
`define CJAR_ADC_14_MS      20
`define CJAR_ADC_12_MS      5
`define CJAR_CLK_HZ         40000000
`define CJAR_RES_18         2'h0
`define CJAR_RES_16         2'h1
`define CJAR_RES_14         2'h2
`define CJAR_RES_12         2'h3
`define CJAR_CJ_FINE_MASK   12'hfff
`define CJAR_CJ_COARSE_MASK 12'hffc
`define CJAR_ADC_18_MASK    18'h3_ffff
`define CJAR_ADC_16_MASK    18'h3_fffc
`define CJAR_ADC_14_MASK    18'h3_fff0
`define CJAR_ADC_12_MASK    18'h3_ffc0
`endif

// ===== cjar_checker.sv
// Assertions on the result registers and their update strobes.
`timescale 1ns/1ps
module cjar_checker(
    input wire        clk_in, rstn_in, cj_coarse_in, cj_update_out, adc_update_out,
    input wire [1:0]  adc_res_in,
    input wire [11:0] cj_sample_in,
    input wire [17:0] adc_sample_in,
    input wire [15:0] cold_junction_temperature_out,
    input wire [23:0] raw_adc_sample_out);
wire [15:0] cj = cold_junction_temperature_out;
wire [23:0] ad = raw_adc_sample_out;
default clocking @(posedge clk_in); endclocking
default disable iff (!rstn_in);
// Gap lengths follow the short periods the bench gives the block: 8 coarse, 4 at 12 bits.
sequence cj_gap; !cj_update_out[*7] ##1 cj_update_out; endsequence
sequence adc_gap; !adc_update_out[*3] ##1 adc_update_out; endsequence
a_cj_sign_fill: assert property (cj[15:12] == {4{cj[11]}}) else $error("cj sign");
a_adc_sign_fill: assert property (ad[23:17] == {7{ad[17]}}) else $error("adc sign");
a_cj_load_value: assert property (cj_update_out |-> cj[11:0] == ($past(cj_sample_in)
    & ($past(cj_coarse_in) ? 12'h0FFC : 12'h0FFF))) else $error("cj load");
a_adc_load_value: assert property (adc_update_out |-> ad[17:0] == ($past(adc_sample_in)
    & (18'h3_FFFF << 2 * $past(adc_res_in)))) else $error("adc load");
a_cj_hold_whole: assert property (!cj_update_out |-> $stable(cj)) else $error("cj hold");
a_adc_hold_whole: assert property (!adc_update_out |-> $stable(ad)) else $error("adc hold");
a_cj_coarse_gap: assert property (cj_update_out && cj_coarse_in |=> cj_gap) else $error("cj gap");
a_adc_fast_gap: assert property (adc_update_out && adc_res_in == 3 |=> adc_gap) else $error("gap");
endmodule

// ===== cjar_front.sv
// Front-end model that presents converter samples to the result block.
`timescale 1ns/1ps
module cjar_front(
    input  wire logic        clk_in,
    input  wire logic [11:0] cj_set_in,
    input  wire logic [17:0] adc_set_in,
    output logic      [11:0] cj_out,
    output logic      [17:0] adc_out);
// Samples are full-width two's complement words (12-bit cold junction, 18-bit ADC); the block does the masking.
always @(posedge clk_in) begin
    cj_out <= cj_set_in;
    adc_out <= adc_set_in;
end
endmodule

// ===== cjar_readout_test.sv
// Self-checking bench for the result register block.
`timescale 1ns/1ps
module cjar_readout_test;
logic clk_in = 0, rstn_in = 0, cj_coarse_in = 0;
logic [1:0] adc_res_in = 0;
logic [11:0] cj_set = 0, cj_sample_in;
logic [17:0] adc_set = 0, adc_sample_in;
wire [15:0] cj;
wire [23:0] ad;
wire cj_up, ad_up;
int errors = 0, n_checks = 0, cyc = 0;
always #12.5 clk_in = ~clk_in;
cjar_front u_front(.clk_in(clk_in), .cj_set_in(cj_set), .adc_set_in(adc_set),
    .cj_out(cj_sample_in), .adc_out(adc_sample_in));
localparam int CJ_FINE = 20, CJ_COARSE = 8, ADC_18 = 32, ADC_16 = 16, ADC_14 = 8, ADC_12 = 4;
cjar_readout #(.CJ_FINE_CYCLES(CJ_FINE), .CJ_COARSE_CYCLES(CJ_COARSE),
    .ADC_18_CYCLES(ADC_18), .ADC_16_CYCLES(ADC_16), .ADC_14_CYCLES(ADC_14),
    .ADC_12_CYCLES(ADC_12)) u_dut(.clk_in(clk_in), .rstn_in(rstn_in),
    .cj_coarse_in(cj_coarse_in), .adc_res_in(adc_res_in), .cj_sample_in(cj_sample_in),
    .adc_sample_in(adc_sample_in), .cold_junction_temperature_out(cj),
    .raw_adc_sample_out(ad), .cj_update_out(cj_up), .adc_update_out(ad_up));
task chk(input string nm, input logic [23:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
        errors++;
        $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
endtask
task wrap_up;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
endtask
// Each mode runs from a fresh reset so that a period never straddles a mode change.
task run(input logic c, input logic [1:0] r, input logic [11:0] s, input logic [17:0] a);
    int k, cj_at, adc_p, t16, e16;
    @(posedge clk_in);
    rstn_in <= 0;
    cj_coarse_in <= c;
    adc_res_in <= r;
    cj_set <= s;
    adc_set <= a;
    repeat (16) @(posedge clk_in);
    rstn_in <= 1;
    cj_at = c ? CJ_COARSE : CJ_FINE;
    adc_p = (r == 0) ? ADC_18 : (r == 1) ? ADC_16 : (r == 2) ? ADC_14 : ADC_12;
    k = 0;
    #1 chk("cold", cj, 0);
    chk("raw", ad, 0);
    repeat (40) begin @(posedge clk_in); #1; k++; if (cj_up) break; end
    chk("cj strobe", cj_up, 1);
    chk("cj period", k, cj_at);
    chk("cold", cj, {{4{s[11]}}, s & (c ? 12'h0FFC : 12'h0FFF)});
    // The host rebuilds sixteenths of a degree from the two bytes.
    t16 = cj[15:8] * 256 + cj[7:0] - (cj[15] ? 65536 : 0);
    e16 = $signed(s & (c ? 12'h0FFC : 12'h0FFF));
    chk("host value", t16, e16);
    repeat (40) begin @(posedge clk_in); #1; k++; if (ad_up) break; end
    chk("adc strobe", ad_up, 1);
    chk("adc period", k, adc_p * (cj_at / adc_p + 1));
    chk("raw", ad, {{6{a[17]}}, a & (18'h3_FFFF << 2 * r)});
endtask
always @(posedge clk_in) if (++cyc > 1000) begin errors++; wrap_up; end
initial begin
    run(0, 0, 12'hA5B, 18'h2_B3C7);
    run(1, 1, 12'h193, 18'h1_5A5F);
    run(0, 2, 12'h7F1, 18'h3_0003);
    run(1, 3, 12'hE07, 18'h0_FFFF);
    wrap_up;
end
endmodule
bind cjar_readout cjar_checker u_chk(.clk_in(clk_in), .rstn_in(rstn_in),
    .cj_coarse_in(cj_coarse_in), .cj_update_out(cj_update_out),
    .adc_update_out(adc_update_out), .adc_res_in(adc_res_in),
    .cj_sample_in(cj_sample_in), .adc_sample_in(adc_sample_in),
    .cold_junction_temperature_out(cold_junction_temperature_out),
    .raw_adc_sample_out(raw_adc_sample_out));
